// ===== core/tsc_pkg.sv
// Purpose: Shared constants and types of the tuner synthesizer control core
// Assumes: One 125 MHz system clock; all input pins except the asynchronous reset arst_n sampled into that domain
// Notes:   Data-byte bit positions, reset values of programmed values and divider counts live here
package tsc_pkg;

  // System clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CLK_HZ        = 125000000;

  // Reference path: crystal divided by a fixed ratio
  localparam int unsigned XTAL_HZ      = 4000000;
  localparam int unsigned REF_HZ_MILLI = 7812500;
  localparam int unsigned REF_DIV      = 512;
  localparam int unsigned REF_CNT_W    = 9;
  localparam logic [8:0]  REF_LAST     = 9'h1FF;
  localparam logic [8:0]  REF_HALF     = 9'h100;

  // Feedback path: input already prescaled by a fixed 8
  localparam int unsigned PRESCALE  = 8;
  localparam int unsigned RATIO_W   = 15;
  localparam logic [14:0] RATIO_MIN = 15'h0100;
  localparam logic [14:0] RATIO_MAX = 15'h7FFF;
  localparam logic [14:0] RATIO_RST = 15'h0100;

  // Serial bus framing
  localparam logic [4:0] ADDR_FIXED    = 5'h18;
  localparam logic       DIR_WRITE     = 1'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int unsigned SYNC_STAGES  = 3;

  // Field positions inside data bytes
  localparam int unsigned TYPE_BIT      = 7;
  localparam int unsigned CW1_CUR_BIT   = 6;
  localparam int unsigned CW1_TEST_BIT  = 5;
  localparam int unsigned CW1_TRI_BIT   = 4;
  localparam int unsigned CW1_OS_BIT    = 0;
  localparam int unsigned CW2_PORT_MSB  = 7;
  localparam int unsigned CW2_PORT_LSB  = 4;
  localparam int unsigned CW2_BAND_MSB  = 2;
  localparam int unsigned CW2_BAND_LSB  = 0;

  // Values after reset
  localparam logic [3:0] PORT_RST = 4'h0;
  localparam logic [2:0] BAND_RST = 3'h0;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RECV = 2'b01,
    PH_ACK  = 2'b10,
    PH_SKIP = 2'b11
  } tsc_phase_t;

  // Decoded level on the address-select pin
  typedef enum logic [1:0] {
    CAS_GND  = 2'b00,
    CAS_OPEN = 2'b01,
    CAS_MID  = 2'b10,
    CAS_FULL = 2'b11
  } tsc_cas_t;

  typedef struct packed {
    logic pump_current_high;
    logic test_routing;
    logic pump_tristate;
    logic filter_out_disable;
  } tsc_loop_ctrl_t;

  localparam tsc_loop_ctrl_t LOOP_CTRL_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    // Pin synchronisers, index 0 is the first stage
    logic [2:0]     scl_q;
    logic [2:0]     sda_q;
    logic [2:0]     xtal_q;
    logic [2:0]     fin_q;
    logic [5:0]     cas_q;
    logic           scl_f;
    logic           sda_f;
    logic           xtal_f;
    logic           fin_f;
    logic [1:0]     strap;
    // Bus slave
    tsc_phase_t     phase;
    logic [3:0]     bitcnt;
    logic [7:0]     shreg;
    logic           is_data;
    logic           second;
    logic           kind_ratio;
    logic [6:0]     ratio_hi;
    logic           ack;
    // Programmed values
    logic [14:0]    ratio;
    tsc_loop_ctrl_t loop;
    logic [3:0]     port;
    logic [2:0]     band;
    // Dividers and detector
    logic [8:0]     ref_cnt;
    logic           ref_clk;
    logic [14:0]    div_cnt;
    logic           div_clk;
    logic           up;
    logic           dn;
    // Registered pin drives
    logic           pump_up;
    logic           pump_dn;
    logic           pump_oe;
    logic [3:0]     port_oe;
    logic [2:0]     band_oe;
  } tsc_state_t;

endpackage : tsc_pkg

// ===== core/tsc_synth_ctrl.sv
// Purpose: Two-wire write-only slave plus reference/feedback dividers and
//          phase/frequency detector of a tuner synthesizer
// Assumes: clk at 125 MHz, far faster than crystal, prescaled input and SCL
// Notes:   Analog parts stay outside; pump and ports leave as drive enables
//
// How it works
// - Crystal divided by 512 gives reference
// - Prescaled input divided by programmable ratio
// - Earlier divided edge pulses up, else down
// - In phase means no pump pulse
// - Tristate bit forces pump output off
// - Filter disable bit disconnects amplifier output
// - Pump current bit selects high current
// - Test bit routes reference, divided input out
// - Band outputs active where bit is one
// - Port outputs active where bit is one, ports 2 and 3 only with test bit off
// - Start and stop framed by SDA under SCL
// - Data bits sampled on rising SCL
// - Bytes MSB first, acknowledge on ninth clock
// - Address must be 11000 plus strap bits
// - Only write direction is answered
// - Strap bits decoded from address pin level
// - First and third byte MSB selects type
// - Second byte of a pair is same type
// - Ratio is unsigned fifteen bit binary
// - Control byte one layout decoded
// - Control byte two layout decoded
// - No SDA pull during power-on reset
`timescale 1ns/1ps

module tsc_synth_ctrl
  import tsc_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Serial bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output wire logic        sda_o,
  output wire logic        sda_oe,
  // Address-select pin level from the comparator
  input  wire tsc_cas_t    cas_level,
  // Synthesizer inputs
  input  wire logic        xtal_i,
  input  wire logic        prescaled_i,
  // Charge pump and filter amplifier
  output wire logic        pump_up,
  output wire logic        pump_dn,
  output wire logic        charge_pump_oe,
  output wire logic        pump_current_high,
  output wire logic        filter_amp_enable,
  // Open-collector outputs, high while sinking
  output wire logic [2:0]  band_out_oe,
  output wire logic [3:0]  port_out_oe,
  // Observed state
  output wire logic [14:0] ratio_value
);

  tsc_state_t s;
  tsc_state_t s_n;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        addr_ok;
  logic        xtal_rise;
  logic        fin_rise;
  logic        ref_fall;
  logic        div_fall;
  logic [14:0] new_ratio;
  logic [14:0] ratio_last;
  logic [14:0] half_ratio;

  function automatic logic [1:0] strap_bits(input tsc_cas_t lvl);
    logic [1:0] bits;
    bits = 2'h0;
    unique case (lvl)
      CAS_GND:  bits = 2'h0;
      CAS_OPEN: bits = 2'h1;
      CAS_MID:  bits = 2'h2;
      CAS_FULL: bits = 2'h3;
    endcase
    return bits;
  endfunction : strap_bits

  always_comb begin
    s_n        = s;
    scl_rise   = 1'b0;
    scl_fall   = 1'b0;
    start_seen = 1'b0;
    stop_seen  = 1'b0;
    addr_ok    = 1'b0;
    xtal_rise  = 1'b0;
    fin_rise   = 1'b0;
    ref_fall   = 1'b0;
    div_fall   = 1'b0;
    new_ratio  = {s.ratio_hi, s.shreg};
    ratio_last = s.ratio - 15'h0001;
    half_ratio = {1'b0, s.ratio[14:1]};

    // Three-stage synchronisers; a level counts once stages two and
    // three agree, so a single-sample glitch never reaches the slave
    s_n.scl_q  = {s.scl_q[1:0], scl_i};
    s_n.sda_q  = {s.sda_q[1:0], sda_i};
    s_n.xtal_q = {s.xtal_q[1:0], xtal_i};
    s_n.fin_q  = {s.fin_q[1:0], prescaled_i};
    s_n.cas_q  = {s.cas_q[3:0], cas_level};
    if (s.scl_q[1] == s.scl_q[2]) begin
      s_n.scl_f = s.scl_q[2];
    end
    if (s.sda_q[1] == s.sda_q[2]) begin
      s_n.sda_f = s.sda_q[2];
    end
    if (s.xtal_q[1] == s.xtal_q[2]) begin
      s_n.xtal_f = s.xtal_q[2];
    end
    if (s.fin_q[1] == s.fin_q[2]) begin
      s_n.fin_f = s.fin_q[2];
    end
    if (s.cas_q[3:2] == s.cas_q[5:4]) begin
      s_n.strap = strap_bits(tsc_cas_t'(s.cas_q[5:4]));
    end

    scl_rise  = ~s.scl_f & s_n.scl_f;
    scl_fall  = s.scl_f & ~s_n.scl_f;
    xtal_rise = ~s.xtal_f & s_n.xtal_f;
    fin_rise  = ~s.fin_f & s_n.fin_f;

    // SDA moving while SCL stays high frames a telegram
    start_seen = s.scl_f & s_n.scl_f & s.sda_f & ~s_n.sda_f;
    stop_seen  = s.scl_f & s_n.scl_f & ~s.sda_f & s_n.sda_f;

    addr_ok = (s.shreg[7:3] == ADDR_FIXED)
            & (s.shreg[2:1] == s.strap)
            & (s.shreg[0] == DIR_WRITE);

    if (start_seen) begin
      // A start always rearms the slave, also after a foreign address
      s_n.phase   = PH_RECV;
      s_n.bitcnt  = 4'h0;
      s_n.is_data = 1'b0;
      s_n.second  = 1'b0;
      s_n.ack     = 1'b0;
    end else if (stop_seen) begin
      // A pending first ratio byte is simply dropped here
      s_n.phase  = PH_IDLE;
      s_n.ack    = 1'b0;
      s_n.second = 1'b0;
    end else begin
      unique case (s.phase)
        PH_IDLE: begin
          s_n.ack = 1'b0;
        end
        PH_SKIP: begin
          s_n.ack = 1'b0;
        end
        PH_RECV: begin
          if (scl_rise && s.bitcnt != BITS_PER_BYTE) begin
            s_n.shreg  = {s.shreg[6:0], s.sda_f};
            s_n.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == BITS_PER_BYTE) begin
            if (s.is_data || addr_ok) begin
              s_n.ack   = 1'b1;
              s_n.phase = PH_ACK;
            end else begin
              s_n.phase = PH_SKIP;
            end
          end
        end
        PH_ACK: begin
          // Ninth clock ends on its falling edge; the byte is committed
          // only now, after the master has seen the acknowledge
          if (scl_fall) begin
            s_n.ack     = 1'b0;
            s_n.phase   = PH_RECV;
            s_n.bitcnt  = 4'h0;
            s_n.is_data = 1'b1;
            if (s.is_data && !s.second) begin
              s_n.second = 1'b1;
              if (!s.shreg[TYPE_BIT]) begin
                s_n.kind_ratio = 1'b1;
                s_n.ratio_hi   = s.shreg[6:0];
              end else begin
                s_n.kind_ratio = 1'b0;
                s_n.loop.pump_current_high  = s.shreg[CW1_CUR_BIT];
                s_n.loop.test_routing       = s.shreg[CW1_TEST_BIT];
                s_n.loop.pump_tristate      = s.shreg[CW1_TRI_BIT];
                s_n.loop.filter_out_disable = s.shreg[CW1_OS_BIT];
              end
            end else if (s.is_data) begin
              // Second byte takes the type of the first one
              s_n.second = 1'b0;
              if (s.kind_ratio) begin
                // Ratios below the usable range are refused, keeping the
                // divider from a degenerate count
                if (new_ratio >= RATIO_MIN) begin
                  s_n.ratio = new_ratio;
                end
              end else begin
                s_n.port = s.shreg[CW2_PORT_MSB:CW2_PORT_LSB];
                s_n.band = s.shreg[CW2_BAND_MSB:CW2_BAND_LSB];
              end
            end
          end
        end
      endcase
    end

    // Reference divider, counts crystal periods
    if (xtal_rise) begin
      if (s.ref_cnt == REF_LAST) begin
        s_n.ref_cnt = 9'h000;
      end else begin
        s_n.ref_cnt = s.ref_cnt + 9'h001;
      end
    end
    s_n.ref_clk = (s_n.ref_cnt < REF_HALF);

    // Feedback divider; the >= compare lets a new smaller ratio take
    // effect within one period instead of wrapping the whole counter
    if (fin_rise) begin
      if (s.div_cnt >= ratio_last) begin
        s_n.div_cnt = 15'h0000;
      end else begin
        s_n.div_cnt = s.div_cnt + 15'h0001;
      end
    end
    s_n.div_clk = (s_n.div_cnt < half_ratio);

    ref_fall = s.ref_clk & ~s_n.ref_clk;
    div_fall = s.div_clk & ~s_n.div_clk;

    // Three-state detector: each falling edge arms its side; once both
    // sides are armed the overlap is cancelled
    s_n.up = s.up | div_fall;
    s_n.dn = s.dn | ref_fall;
    if (s_n.up && s_n.dn) begin
      s_n.up = 1'b0;
      s_n.dn = 1'b0;
    end

    s_n.pump_up = s_n.up & ~s_n.loop.pump_tristate;
    s_n.pump_dn = s_n.dn & ~s_n.loop.pump_tristate;
    s_n.pump_oe = (s_n.up | s_n.dn) & ~s_n.loop.pump_tristate;

    s_n.band_oe = s_n.band;
    s_n.port_oe[1:0] = s_n.port[1:0];
    if (s_n.loop.test_routing) begin
      s_n.port_oe[2] = s_n.ref_clk;
      s_n.port_oe[3] = s_n.div_clk;
    end else begin
      s_n.port_oe[3:2] = s_n.port[3:2];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Bus lines idle high, so filtered levels start high to keep a
      // release from looking like a start
      s         <= '0;
      s.scl_q   <= 3'h7;
      s.sda_q   <= 3'h7;
      s.scl_f   <= 1'b1;
      s.sda_f   <= 1'b1;
      s.phase   <= PH_IDLE;
      s.ack     <= 1'b0;
      s.ratio   <= RATIO_RST;
      s.loop    <= LOOP_CTRL_RST;
      s.port    <= PORT_RST;
      s.band    <= BAND_RST;
      s.ref_clk <= 1'b1;
    end else begin
      s <= s_n;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_o             = 1'b0;
  assign sda_oe            = s.ack;
  assign pump_up           = s.pump_up;
  assign pump_dn           = s.pump_dn;
  assign charge_pump_oe    = s.pump_oe;
  assign pump_current_high = s.loop.pump_current_high;
  assign filter_amp_enable = ~s.loop.filter_out_disable;
  assign band_out_oe       = s.band_oe;
  assign port_out_oe       = s.port_oe;
  assign ratio_value       = s.ratio;

endmodule : tsc_synth_ctrl

// ===== tb/tsc_bus_master.sv
// Purpose: Two-wire bus master model writing telegrams to the core
// Assumes: Each SCL level is held 8 clk; pins change on falling clk
// Notes:   Open drain, so a pull-up gives high when nobody pulls
`timescale 1ns/1ps
module tsc_bus_master (
  // Clock
  input  wire logic clk,
  // Device pull and bus levels
  input  wire logic dev_pull,
  output var  logic scl,
  output wire logic sda
);
  logic pull_low = 1'b0;
  assign sda = !(pull_low || dev_pull);
  initial scl = 1'b1;
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  task automatic start;
    pull_low = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(4);
  endtask : start
  // Data moves 4 clk after SCL falls, so setup and hold both get 4
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      pull_low = !b[i];
      hold(4);
      scl = 1'b1;
      hold(8);
      scl = 1'b0;
      hold(4);
    end
    pull_low = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    ack = !sda;
    hold(4);
    scl = 1'b0;
    hold(4);
  endtask : send
  task automatic stop;
    pull_low = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    pull_low = 1'b0;
    hold(8);
  endtask : stop
endmodule : tsc_bus_master

// ===== tb/tsc_synth_ctrl_sva.sv
// Purpose: Port assertions for the synthesizer control core
// Assumes: Master holds SCL low 8 clk around every update
// Notes:   Register updates must land inside an SCL low phase
`timescale 1ns/1ps
module tsc_synth_ctrl_sva
  import tsc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Bus pins
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // Loop and outputs
  input wire logic        pump_up,
  input wire logic        pump_dn,
  input wire logic        charge_pump_oe,
  input wire logic        pump_current_high,
  input wire logic        filter_amp_enable,
  input wire logic [2:0]  band_out_oe,
  input wire logic [14:0] ratio_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_ack_held;
    sda_oe [*8];
  endsequence
  sequence s_ack_ends;
    ##[8:40] !sda_oe;
  endsequence
  a_drain_only: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_ack_held: assert property ($rose(sda_oe) |-> s_ack_held)
    else $error("acknowledge too short");
  a_ack_released: assert property ($rose(sda_oe) |-> s_ack_ends)
    else $error("acknowledge never released");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("acknowledge while clock high");
  a_pump_exclusive: assert property (!(pump_up && pump_dn))
    else $error("both pump pulses");
  a_pump_oe_tie: assert property (charge_pump_oe == (pump_up || pump_dn))
    else $error("pump enable mismatch");
  a_ratio_floor: assert property (ratio_value >= RATIO_MIN)
    else $error("ratio below range");
  a_ratio_commit: assert property ($changed(ratio_value) |-> !scl_i && !$past(scl_i, 2))
    else $error("ratio changed outside ack end");
  a_band_commit: assert property ($changed(band_out_oe) |-> !scl_i)
    else $error("band changed while clock high");
  a_ctrl_commit: assert property ($changed({pump_current_high, filter_amp_enable}) |-> !scl_i)
    else $error("control changed while clock high");
endmodule : tsc_synth_ctrl_sva
bind tsc_synth_ctrl tsc_synth_ctrl_sva i_sva (.clk(clk), .arst_n(arst_n), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .pump_up(pump_up), .pump_dn(pump_dn),
  .charge_pump_oe(charge_pump_oe), .pump_current_high(pump_current_high),
  .filter_amp_enable(filter_amp_enable), .band_out_oe(band_out_oe), .ratio_value(ratio_value));

// ===== tb/test_tsc_synth_ctrl.sv
// Purpose: Self-checking bench for the synthesizer control core
// Assumes: Crystal and prescaled input run far faster than real
// Notes:   Loop behaviour judged by which pulses appear in a window
`timescale 1ns/1ps
module test_tsc_synth_ctrl
  import tsc_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        xtal = 1'b0;
  logic        pre = 1'b0;
  tsc_cas_t    cas = CAS_GND;
  wire logic   scl;
  wire logic   sda;
  logic        sda_o, sda_oe, p_up, p_dn, p_oe, cur, filt, ack;
  logic [2:0]  band;
  logic [3:0]  port;
  logic [14:0] ratio;
  logic [5:0]  w;
  int          n_fail = 0;
  int          comparisons = 0;
  initial forever #4 clk = ~clk;
  initial forever begin
    repeat (2) @(negedge clk);
    xtal = ~xtal;
  end
  initial forever begin
    repeat (2) @(negedge clk);
    pre = ~pre;
  end
  tsc_synth_ctrl i_dut (.clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .cas_level(cas), .xtal_i(xtal), .prescaled_i(pre), .pump_up(p_up),
    .pump_dn(p_dn), .charge_pump_oe(p_oe), .pump_current_high(cur),
    .filter_amp_enable(filt), .band_out_oe(band), .port_out_oe(port), .ratio_value(ratio));
  tsc_bus_master i_mst (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
  task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
    comparisons++;
    if (seen_v !== exp_v) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic [7:0] adr(input logic [1:0] s);
    return {ADDR_FIXED, s, DIR_WRITE};
  endfunction : adr
  // Address ack lands in ack; data acks are not needed by the checks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int nb);
    logic k;
    i_mst.start();
    i_mst.send(a, ack);
    for (int i = 0; i < nb; i++) begin
      i_mst.send(d[31-8*i -: 8], k);
    end
    i_mst.stop();
  endtask : wr
  task automatic watch(input int n);
    w = '0;
    repeat (n) begin
      @(negedge clk);
      w |= {p_up, p_dn, port[2], !port[2], port[3], !port[3]};
    end
  endtask : watch
  initial begin
    logic [14:0] r;
    logic [15:0] d;
    void'($urandom(41451));
    repeat (7) @(negedge clk);
    check({15'h0, sda_oe}, 16'h0000);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
    check({1'b0, ratio}, 16'h0100);
    check({6'h0, band, port, cur, filt, p_oe}, 16'h0002);
    for (int s = 0; s < 4; s++) begin
      cas = tsc_cas_t'(s);
      repeat (8) @(negedge clk);
      r = (s == 0) ? 15'h0100 : (s == 3) ? 15'h7FFF : 15'($urandom_range(32766, 257));
      wr(adr(2'(s)), {1'b0, r, 16'h0}, 2);
      check({15'h0, ack}, 16'h0001);
      check({1'b0, ratio}, {1'b0, r});
      wr(adr(2'(s) ^ 2'h1), 32'h1234_0000, 2);
      check({15'h0, ack}, 16'h0000);
      wr(adr(2'(s)) | 8'h01, 32'h2345_0000, 2);
      check({15'h0, ack}, 16'h0000);
      wr(adr(2'(s)), 32'h3300_0000, 1);
      check({1'b0, ratio}, {1'b0, r});
    end
    repeat (6) begin
      d = 16'($urandom);
      wr(adr(2'h3), {1'b1, d[14], 1'b0, d[12], 3'h7, d[8], d[7:0], 16'h0}, 2);
      check({14'h0, cur, filt}, {14'h0, d[14], !d[8]});
      check({9'h0, port, band}, {9'h0, d[7:4], d[2:0]});
    end
    wr(adr(2'h3), 32'h9E00_0100, 4);
    check({1'b0, ratio}, 16'h0100);
    watch(4000);
    check({14'h0, w[5:4]}, 16'h0000);
    wr(adr(2'h3), 32'hAE00_0000, 2);
    watch(4000);
    check({11'h0, w[5], w[3:0]}, 16'h001F);
    wr(adr(2'h3), 32'h8E00_7FFF, 4);
    // Nearly three reference periods, so one unanswered falling edge is certain
    watch(6000);
    check({13'h0, w[4], w[3:2]}, 16'h0005);
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule : test_tsc_synth_ctrl
